// File: uart_shadow_defines.vh
// constants for the shadow data port: offsets, fields, reset values, timing
// assumes byte addresses on a 32-bit register port, word aligned
`ifndef UART_SHADOW_DEFINES_VH
`define UART_SHADOW_DEFINES_VH

`define SLOT_FIRST_ADDR 32'h50001130
`define SLOT_LAST_ADDR 32'h5000116C
`define SLOT_EIGHT_ADDR 32'h50001150
`define LSW_ADDR 32'h50001200
`define FCW_ADDR 32'h50001204
`define MODE_ADDR 32'h50001208
`define DIV_ADDR 32'h5000120C
`define ISTAT_ADDR 32'h50001210
`define IMASK_ADDR 32'h50001214

`define LSW_DR_BIT 0
`define LSW_OE_BIT 1
`define LSW_FE_BIT 3
`define LSW_TX_HOLDING_EMPTY_FLAG_BIT 5
`define LSW_TEMT_BIT 6
`define FCW_EN_BIT 0
`define FCW_RXCLR_BIT 1
`define FCW_TXCLR_BIT 2
`define MODE_IR_BIT 0

`define INT_RX_BIT 0
`define INT_OVR_BIT 1
`define INT_TXE_BIT 2
`define INT_W 3

`define FIFO_DEPTH 5'h10
`define FIFO_AW 4
`define DIV_RESET 16'h000A
`define TICKS_PER_BIT 4'hF
`define TICK_HALF 4'h7
`define IR_PULSE_TICKS 4'h3
`define IR_HOLD_TICKS 5'h10
`define FRAME_BITS 4'h9
`define DATA_BITS 4'h8

`endif

// File: uart_fifo_mem.v
// sixteen by eight storage for one character queue, registered read data
// assumes the owner keeps pointers and counts; one clock, synchronous reset
module uart_fifo_mem (
  input wire mclk_i,
  input wire reset_n_i,
  input wire we_i,
  input wire [3:0] waddr_i,
  input wire [7:0] wdata_i,
  input wire re_i,
  input wire [3:0] raddr_i,
  output reg [7:0] rdata_o
);
  reg [7:0] mem_q [0:15];

  always @(posedge mclk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
    end else if (re_i) begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule

// File: uart_shadow_data_port.v
// shadow receive/transmit data slots of a serial port with infrared option
// assumes a register master on mclk_i; serial pins come from outside the clock domain
`include "uart_shadow_defines.vh"

module uart_shadow_data_port (
  input wire mclk_i,
  input wire reset_n_i,
  input wire [31:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [31:0] rdata_o,
  input wire sin_i,
  input wire sir_in_i,
  output wire sout_o,
  output wire sir_out_n_o,
  output wire irq_o
);
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;
  localparam TX_IDLE = 2'h0;
  localparam TX_LOAD = 2'h1;
  localparam TX_SHIFT = 2'h2;

  function [3:0] ptr_next;
    input [3:0] p;
    begin
      ptr_next = p + 4'h1;
    end
  endfunction

  function [4:0] depth_lim;
    input en;
    begin
      depth_lim = en ? `FIFO_DEPTH : 5'h01;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire slot_hit;
  wire slot_rd;
  wire slot_wr;
  assign slot_hit = (addr_i >= `SLOT_FIRST_ADDR) && (addr_i <= `SLOT_LAST_ADDR) && (addr_i[1:0] == 2'h0);
  assign slot_rd = rd_i && slot_hit;
  assign slot_wr = wr_i && slot_hit;

  reg fifo_en_q;
  reg ir_mode_q;
  reg [15:0] div_q;
  reg [`INT_W-1:0] istat_q;
  reg [`INT_W-1:0] imask_q;
  reg overrun_q;
  reg frame_err_q;
  reg [31:0] rdata_q;
  reg slot_sel_q;
  reg rx_clr;
  reg tx_clr;

  ////////////////////////////////////////////////////////////////////////////
  // queues
  reg [3:0] rx_wp_q;
  reg [3:0] rx_rp_q;
  reg [4:0] rx_cnt_q;
  reg [3:0] tx_wp_q;
  reg [3:0] tx_rp_q;
  reg [4:0] tx_cnt_q;
  wire [7:0] rx_head;
  wire [7:0] tx_head;
  reg rx_push;
  reg [7:0] rx_byte_q;
  wire rx_full;
  wire rx_pop;
  wire rx_we;
  wire [3:0] rx_waddr;
  wire tx_full;
  wire tx_push;
  wire tx_pop;

  assign rx_full = (rx_cnt_q == depth_lim(fifo_en_q));
  assign rx_pop = slot_rd && (rx_cnt_q != 5'h00);
  // full queue keeps its data; single holding register is overwritten
  assign rx_we = rx_push && (!rx_full || !fifo_en_q);
  assign rx_waddr = (rx_full && !fifo_en_q) ? rx_rp_q : rx_wp_q;
  assign tx_full = (tx_cnt_q == depth_lim(fifo_en_q));
  assign tx_push = slot_wr && (!tx_full || !fifo_en_q);

  uart_fifo_mem u_rx_mem (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .we_i(rx_we),
    .waddr_i(rx_waddr),
    .wdata_i(rx_byte_q),
    .re_i(rx_pop),
    .raddr_i(rx_rp_q),
    .rdata_o(rx_head)
  );

  uart_fifo_mem u_tx_mem (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .we_i(tx_push),
    .waddr_i((tx_full && !fifo_en_q) ? tx_rp_q : tx_wp_q),
    .wdata_i(wdata_i[7:0]),
    .re_i(tx_pop),
    .raddr_i(tx_rp_q),
    .rdata_o(tx_head)
  );

  always @(posedge mclk_i) begin
    if (!reset_n_i || rx_clr) begin
      rx_wp_q <= 4'h0;
      rx_rp_q <= 4'h0;
      rx_cnt_q <= 5'h00;
    end else begin
      if (rx_pop) begin
        rx_rp_q <= ptr_next(rx_rp_q);
      end
      if (rx_we && !rx_full) begin
        rx_wp_q <= ptr_next(rx_wp_q);
      end
      if ((rx_we && !rx_full) && !rx_pop) begin
        rx_cnt_q <= rx_cnt_q + 5'h01;
      end else if (!(rx_we && !rx_full) && rx_pop) begin
        rx_cnt_q <= rx_cnt_q - 5'h01;
      end
    end
  end

  always @(posedge mclk_i) begin
    if (!reset_n_i || tx_clr) begin
      tx_wp_q <= 4'h0;
      tx_rp_q <= 4'h0;
      tx_cnt_q <= 5'h00;
    end else begin
      if (tx_pop) begin
        tx_rp_q <= ptr_next(tx_rp_q);
      end
      // a write to the full single holder replaces the byte in place
      if (tx_push && !tx_full) begin
        tx_wp_q <= ptr_next(tx_wp_q);
      end
      if ((tx_push && !tx_full) && !tx_pop) begin
        tx_cnt_q <= tx_cnt_q + 5'h01;
      end else if (!(tx_push && !tx_full) && tx_pop) begin
        tx_cnt_q <= tx_cnt_q - 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // baud tick and pin synchronisers
  reg [15:0] div_cnt_q;
  wire tick;
  assign tick = (div_cnt_q == 16'h0000);

  always @(posedge mclk_i) begin
    if (!reset_n_i || tick) begin
      div_cnt_q <= div_q;
    end else begin
      div_cnt_q <= div_cnt_q - 16'h0001;
    end
  end

  reg [2:0] sin_sync_q;
  reg [2:0] sir_sync_q;
  reg sin_q;
  reg sir_q;
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sin_sync_q <= 3'h7;
      sir_sync_q <= 3'h0;
      sin_q <= 1'b1;
      sir_q <= 1'b0;
    end else begin
      sin_sync_q <= {sin_sync_q[1:0], sin_i};
      sir_sync_q <= {sir_sync_q[1:0], sir_in_i};
      if (sin_sync_q[1] == sin_sync_q[2]) begin
        sin_q <= sin_sync_q[2];
      end
      if (sir_sync_q[1] == sir_sync_q[2]) begin
        sir_q <= sir_sync_q[2];
      end
    end
  end

  // an infrared pulse marks a zero bit; hold it low for one bit time
  reg [4:0] ir_hold_q;
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ir_hold_q <= 5'h00;
    end else if (sir_q) begin
      ir_hold_q <= `IR_HOLD_TICKS;
    end else if (tick && (ir_hold_q != 5'h00)) begin
      ir_hold_q <= ir_hold_q - 5'h01;
    end
  end

  wire rx_line;
  assign rx_line = ir_mode_q ? (ir_hold_q == 5'h00) : sin_q;

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  reg [1:0] rx_st_q;
  reg [3:0] rx_tk_q;
  reg [3:0] rx_bit_q;
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rx_st_q <= RX_IDLE;
      rx_tk_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_byte_q <= 8'h00;
      rx_push <= 1'b0;
      frame_err_q <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (tick) begin
        rx_tk_q <= rx_tk_q + 4'h1;
        case (rx_st_q)
          RX_IDLE: begin
            rx_tk_q <= 4'h0;
            if (!rx_line) begin
              rx_st_q <= RX_START;
            end
          end
          RX_START: begin
            if (rx_tk_q == `TICK_HALF) begin
              rx_tk_q <= 4'h0;
              rx_bit_q <= 4'h0;
              rx_st_q <= rx_line ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_tk_q == `TICKS_PER_BIT) begin
              rx_byte_q <= {rx_line, rx_byte_q[7:1]};
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q == `DATA_BITS - 4'h1) begin
                rx_st_q <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rx_tk_q == `TICKS_PER_BIT) begin
              rx_push <= 1'b1;
              frame_err_q <= !rx_line;
              rx_st_q <= RX_IDLE;
            end
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter
  reg [1:0] tx_st_q;
  reg [9:0] tx_sh_q;
  reg [3:0] tx_tk_q;
  reg [3:0] tx_bit_q;
  assign tx_pop = (tx_st_q == TX_IDLE) && (tx_cnt_q != 5'h00);

  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= 10'h3FF;
      tx_tk_q <= 4'h0;
      tx_bit_q <= 4'h0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_pop) begin
            tx_st_q <= TX_LOAD;
          end
        end
        TX_LOAD: begin
          tx_sh_q <= {1'b1, tx_head, 1'b0};
          tx_tk_q <= 4'h0;
          tx_bit_q <= 4'h0;
          tx_st_q <= TX_SHIFT;
        end
        TX_SHIFT: begin
          if (tick) begin
            tx_tk_q <= tx_tk_q + 4'h1;
            if (tx_tk_q == `TICKS_PER_BIT) begin
              tx_sh_q <= {1'b1, tx_sh_q[9:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_bit_q == `FRAME_BITS) begin
                tx_st_q <= TX_IDLE;
              end
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  reg sout_q;
  reg sir_out_n_q;
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sout_q <= 1'b1;
      sir_out_n_q <= 1'b1;
    end else begin
      sout_q <= ir_mode_q ? 1'b1 : tx_sh_q[0];
      sir_out_n_q <= !(ir_mode_q && (tx_st_q == TX_SHIFT) && !tx_sh_q[0] && (tx_tk_q < `IR_PULSE_TICKS));
    end
  end
  assign sout_o = sout_q;
  assign sir_out_n_o = sir_out_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // status, interrupts and register access
  wire tx_holding_empty_flag;
  wire temt;
  wire [7:0] lsw;
  wire ovr_event;
  wire [`INT_W-1:0] int_set;
  assign tx_holding_empty_flag = (tx_cnt_q == 5'h00);
  assign temt = tx_holding_empty_flag && (tx_st_q == TX_IDLE);
  assign ovr_event = rx_push && rx_full;
  assign lsw = {1'b0, temt, tx_holding_empty_flag, 1'b0, frame_err_q, 1'b0, overrun_q, (rx_cnt_q != 5'h00)};
  assign int_set = {(tx_pop && (tx_cnt_q == 5'h01)), ovr_event, rx_push};
  assign irq_o = |(istat_q & imask_q);

  always @* begin
    rx_clr = wr_i && (addr_i == `FCW_ADDR) && wdata_i[`FCW_RXCLR_BIT];
    tx_clr = wr_i && (addr_i == `FCW_ADDR) && wdata_i[`FCW_TXCLR_BIT];
  end

  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      fifo_en_q <= 1'b0;
      ir_mode_q <= 1'b0;
      div_q <= `DIV_RESET;
      imask_q <= {`INT_W{1'b0}};
      istat_q <= {`INT_W{1'b0}};
      overrun_q <= 1'b0;
    end else begin
      if (wr_i && (addr_i == `FCW_ADDR)) begin
        fifo_en_q <= wdata_i[`FCW_EN_BIT];
      end
      if (wr_i && (addr_i == `MODE_ADDR)) begin
        ir_mode_q <= wdata_i[`MODE_IR_BIT];
      end
      if (wr_i && (addr_i == `DIV_ADDR)) begin
        div_q <= wdata_i[15:0];
      end
      if (wr_i && (addr_i == `IMASK_ADDR)) begin
        imask_q <= wdata_i[`INT_W-1:0];
      end
      // set wins over the write-one clear
      if (wr_i && (addr_i == `ISTAT_ADDR)) begin
        istat_q <= (istat_q & ~wdata_i[`INT_W-1:0]) | int_set;
      end else begin
        istat_q <= istat_q | int_set;
      end
      // overrun is cleared by reading the line status word, new overrun wins
      if (ovr_event) begin
        overrun_q <= 1'b1;
      end else if (rd_i && (addr_i == `LSW_ADDR)) begin
        overrun_q <= 1'b0;
      end
    end
  end

  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rdata_q <= 32'h00000000;
      slot_sel_q <= 1'b0;
    end else begin
      slot_sel_q <= slot_rd;
      rdata_q <= 32'h00000000;
      if (rd_i) begin
        case (addr_i)
          `LSW_ADDR: rdata_q <= {24'h000000, lsw};
          `FCW_ADDR: rdata_q <= {31'h00000000, fifo_en_q};
          `MODE_ADDR: rdata_q <= {31'h00000000, ir_mode_q};
          `DIV_ADDR: rdata_q <= {16'h0000, div_q};
          `ISTAT_ADDR: rdata_q <= {29'h00000000, istat_q};
          `IMASK_ADDR: rdata_q <= {29'h00000000, imask_q};
          default: rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // slot reads return the registered head byte, bits above read zero
  assign rdata_o = slot_sel_q ? {24'h000000, rx_head} : rdata_q;
endmodule

// File: uart_shadow_data_port_asserts.sv
// checker for the shadow data port: bus, interrupt and line relations
// assumes the bench writes DIV 0 before traffic and changes mode only when idle
`include "uart_shadow_defines.vh"
module uart_shadow_data_port_asserts (
  input wire mclk_i,
  input wire reset_n_i,
  input wire [31:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire sin_i,
  input wire sir_in_i,
  input wire sout_o,
  input wire sir_out_n_o,
  input wire irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  reg [2:0] msk_q;
  reg ir_q;
  reg fen_q;
  reg [15:0] div_q;
  wire slot = addr_i >= `SLOT_FIRST_ADDR && addr_i <= `SLOT_LAST_ADDR && addr_i[1:0] == 2'h0;
  wire own = addr_i >= `LSW_ADDR && addr_i <= `IMASK_ADDR && addr_i[1:0] == 2'h0;
  wire quick = div_q == 16'h0000;
  ////////////////////////////////////////////////////////////////
  always @(posedge mclk_i) begin
    if (!reset_n_i) begin
      msk_q <= 3'h0;
      ir_q <= 1'b0;
      fen_q <= 1'b0;
      div_q <= `DIV_RESET;
    end else if (wr_i) begin
      if (addr_i == `IMASK_ADDR) msk_q <= wdata_i[2:0];
      if (addr_i == `MODE_ADDR) ir_q <= wdata_i[0];
      if (addr_i == `FCW_ADDR) fen_q <= wdata_i[0];
      if (addr_i == `DIV_ADDR) div_q <= wdata_i[15:0];
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence ir_low3;
    !sir_out_n_o [*3] ##1 sir_out_n_o;
  endsequence
  sequence tx_start;
    ##[1:400] !sout_o;
  endsequence
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside slot");
  chk_slot_upper: assert property (rd_i && slot |=> rdata_o[31:8] == 24'h0)
    else $error("slot upper bits not zero");
  chk_unmapped_rd: assert property (rd_i && !slot && !own |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_mask: assert property (irq_o |-> msk_q != 3'h0 || $past(msk_q) != 3'h0)
    else $error("interrupt with all masked");
  chk_ir_quiet: assert property (!ir_q && !$past(ir_q) |-> sir_out_n_o)
    else $error("infrared output active in normal mode");
  chk_sout_ir: assert property (ir_q && $past(ir_q) |-> sout_o)
    else $error("serial output active in infrared mode");
  chk_tx_start: assert property (wr_i && slot && !fen_q && !ir_q && quick |-> tx_start)
    else $error("written byte never started");
  chk_ir_pulse: assert property ($fell(sir_out_n_o) && quick |-> ir_low3)
    else $error("infrared pulse length wrong");
endmodule
bind uart_shadow_data_port uart_shadow_data_port_asserts chk_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sin_i(sin_i),
  .sir_in_i(sir_in_i), .sout_o(sout_o), .sir_out_n_o(sir_out_n_o), .irq_o(irq_o));

// File: uart_line_partner.sv
// far-side transceiver: drives the serial or infrared input, decodes the serial and infrared outputs
// assumes DIV 0, so one bit is 16 clock cycles
module uart_line_partner (
  input wire mclk_i,
  input wire sout_i,
  input wire sir_out_n_i,
  output logic sin_o,
  output logic sir_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BC = 16;
  logic [7:0] got_q[$];
  initial begin
    sin_o = 1'b1;
    sir_in_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] b, input logic ir);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk_i);
      if (ir) begin
        sir_in_o <= !f[i];
        repeat (3) @(posedge mclk_i);
        sir_in_o <= 1'b0;
        repeat (BC - 4) @(posedge mclk_i);
      end else begin
        sin_o <= f[i];
        repeat (BC - 1) @(posedge mclk_i);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial forever begin
    logic [7:0] b;
    @(negedge sout_i);
    repeat (BC / 2) @(posedge mclk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BC) @(posedge mclk_i);
      b[i] = sout_i;
    end
    repeat (BC) @(posedge mclk_i);
    got_q.push_back(b);
  end
  ////////////////////////////////////////////////////////////////
  // infrared output: a low pulse at the start of a bit marks a zero
  initial forever begin
    logic [7:0] b;
    @(negedge sir_out_n_i);
    @(posedge mclk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BC) @(posedge mclk_i);
      b[i] = sir_out_n_i;
    end
    got_q.push_back(b);
  end
endmodule

// File: uart_shadow_data_port_tb.sv
// self-checking bench for the shadow data port
// assumes the checker binds itself and the partner decodes at DIV 0
`include "uart_shadow_defines.vh"
module uart_shadow_data_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [31:0] addr_i = 32'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  wire [31:0] rdata_o;
  wire sin_i, sir_in_i, sout_o, sir_out_n_o, irq_o;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] v;
  logic [7:0] q[$];
  initial forever #25 mclk_i = !mclk_i;
  uart_shadow_data_port uart_shadow_data_port_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sin_i(sin_i), .sir_in_i(sir_in_i),
    .sout_o(sout_o), .sir_out_n_o(sir_out_n_o), .irq_o(irq_o));
  uart_line_partner uart_line_partner_i (.mclk_i(mclk_i), .sout_i(sout_o), .sir_out_n_i(sir_out_n_o),
    .sin_o(sin_i), .sir_in_o(sir_in_i));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] slot(input int n);
    return `SLOT_FIRST_ADDR + 32'(n * 4);
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
  endtask
  task automatic rdr(input logic [31:0] a);
    bus(1'b0, 1'b1, a, 32'h0);
    bus(1'b0, 1'b0, 32'h0, 32'h0);
    #1 v = rdata_o;
  endtask
  task automatic wrr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, 32'h0, 32'h0);
  endtask
  task automatic rx(input logic [7:0] b, input logic ir);
    uart_line_partner_i.send(b, ir);
    repeat (6) @(posedge mclk_i);
  endtask
  task automatic cmp_rx;
    chk(32'(uart_line_partner_i.got_q.size()), 32'(q.size()));
    foreach (q[i]) chk({24'h0, uart_line_partner_i.got_q[i]}, {24'h0, q[i]});
    uart_line_partner_i.got_q.delete();
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] a, b, c;
    void'($urandom(18593));
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rdr(slot(8));
    chk(v, 32'h0);
    rdr(`LSW_ADDR);
    chk(v & 32'h21, 32'h20);
    rdr(32'h50001300);
    chk(v, 32'h0);
    wrr(`DIV_ADDR, 32'h0);
    wrr(`IMASK_ADDR, 32'h3);
    a = 8'($urandom);
    b = 8'($urandom);
    c = 8'($urandom);
    rx(a, 1'b0);
    rdr(`LSW_ADDR);
    chk(v & 32'h3, 32'h1);
    chk({31'h0, irq_o}, 32'h1);
    rdr(slot($urandom_range(15)));
    chk(v, {24'h0, a});
    rx(a, 1'b0);
    rx(b, 1'b0);
    rdr(`LSW_ADDR);
    chk(v & 32'h3, 32'h3);
    rdr(slot(15));
    chk(v, {24'h0, b});
    wrr(`ISTAT_ADDR, 32'h7);
    wrr(`IMASK_ADDR, 32'h0);
    wrr(`MODE_ADDR, 32'h1);
    rx(c, 1'b1);
    chk({31'h0, irq_o}, 32'h0);
    rdr(`ISTAT_ADDR);
    chk(v & 32'h3, 32'h1);
    rdr(slot(0));
    chk(v, {24'h0, c});
    wrr(`MODE_ADDR, 32'h0);
    wrr(`FCW_ADDR, 32'h1);
    for (int i = 0; i < 17; i++) begin
      q.push_back(8'($urandom));
      rx(q[i], 1'b0);
    end
    rdr(`LSW_ADDR);
    chk(v & 32'h3, 32'h3);
    for (int i = 0; i < 16; i++) begin
      rdr(slot(i));
      chk(v, {24'h0, q[i]});
    end
    rdr(`LSW_ADDR);
    chk(v & 32'h1, 32'h0);
    wrr(`FCW_ADDR, 32'h0);
    wrr(slot(1), {24'h0, a});
    repeat (5) @(posedge mclk_i);
    wrr(slot(2), {24'h0, b});
    rdr(`LSW_ADDR);
    chk(v & 32'h20, 32'h0);
    wrr(slot(3), {24'h0, c});
    repeat (400) @(posedge mclk_i);
    rdr(`LSW_ADDR);
    chk(v & 32'h20, 32'h20);
    q = '{a, c};
    cmp_rx();
    wrr(`FCW_ADDR, 32'h1);
    q.delete();
    q.push_back(a);
    wrr(slot(4), {24'h0, a});
    repeat (5) @(posedge mclk_i);
    for (int i = 1; i < 18; i++) begin
      q.push_back(8'($urandom));
      bus(1'b1, 1'b0, slot(i % 16), {24'h0, q[i]});
    end
    wrr(`ISTAT_ADDR, 32'h7);
    void'(q.pop_back());
    repeat (3000) @(posedge mclk_i);
    rdr(`ISTAT_ADDR);
    chk(v & 32'h4, 32'h4);
    cmp_rx();
    wrr(`MODE_ADDR, 32'h1);
    a = 8'($urandom);
    wrr(slot(5), {24'h0, a});
    repeat (200) @(posedge mclk_i);
    q = '{a};
    cmp_rx();
    wrr(`MODE_ADDR, 32'h0);
    wrap_up();
  end
endmodule
